// *** rtl/osc_cfg_pkg.sv ***
/*
 Constants, types and register map of the oscillator configuration
 decoder. Assumes a 32-bit APB register bus and a 100 MHz clock.

*/
package osc_cfg_pkg;

   // Bus geometry
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] CFG_IDX  = 24'h300001;
   localparam logic [ADDR_W-1:0] TUNE_IDX = 24'h300010;
   localparam logic [ADDR_W-1:0] STAT_IDX = 24'h300011;

   // Field positions
   localparam int TWO_SPEED_BIT = 7;
   localparam int FAILSAFE_BIT  = 6;
   localparam int UNUSED_BIT    = 5;
   localparam int PLL_FUSE_BIT  = 4;
   localparam int SEL_LSB       = 0;
   localparam int SEL_W         = 4;
   localparam int PLL_RUN_BIT   = 6;

   // Reset values
   localparam logic [7:0] CFG_RESET  = 8'h08;
   localparam logic [7:0] TUNE_RESET = 8'h00;

   typedef enum logic [3:0] {
      crystal_low_freq_mode   = 4'b0000,
      crystal_std_mode        = 4'b0001,
      crystal_fast_high       = 4'b0010,
      crystal_fast_med        = 4'b0011,
      ext_clock_high_with_out = 4'b0100,
      ext_clock_high          = 4'b0101,
      ext_resistor_cap_osc_out = 4'b0110,
      ext_resistor_cap_osc    = 4'b0111,
      internal_osc            = 4'b1000,
      internal_osc_clock_out  = 4'b1001,
      ext_clock_med_with_out  = 4'b1010,
      ext_clock_med           = 4'b1011,
      ext_clock_low_with_out  = 4'b1100,
      ext_clock_low           = 4'b1101,
      reserved_e_mode         = 4'b1110,
      reserved_f_mode         = 4'b1111
   } osc_select_e;

   typedef enum logic [0:0] {
      capture_wait = 1'b0,
      running      = 1'b1
   } capture_state_e;

   // Decoded clock-system controls
   typedef struct packed {
      logic        two_speed_startup_en;
      logic        failsafe_monitor_en;
      logic        pll_enable;
      logic        clock_out_fn;
      logic        internal_sel;
      logic        crystal_sel;
      logic        ext_clock_sel;
      logic        rc_sel;
      logic        mode_reserved;
      osc_select_e osc_select;
   } clk_ctrl_s;

endpackage

// *** rtl/oscillator_config_decode.sv ***
/*
 Oscillator configuration decoder: captures the non-volatile
 configuration byte after reset and decodes it into clock-system
 controls; APB slave for the byte, the tuning and a status register.
 Assumes the byte is static on config_byte_in while reset is released.
*/
// Chosen here: the APB register port.
`timescale 1ns/100ps
module oscillator_config_decode (
   // Clock and reset
   input  wire logic                             clk,
   input  wire logic                             reset,
   input  wire logic                             ce,
   // Non-volatile configuration byte
   input  wire logic [7:0]                       config_byte_in,
   // APB slave
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [osc_cfg_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [osc_cfg_pkg::DATA_W-1:0]   pwdata,
   output logic                                  pready,
   output logic                                  pslverr,
   output logic [osc_cfg_pkg::DATA_W-1:0]        prdata,
   // Decoded controls
   output osc_cfg_pkg::clk_ctrl_s                clk_ctrl
);

   osc_cfg_pkg::capture_state_e state;
   logic [7:0]                  osc_config_high;
   logic [7:0]                  osc_tune_reg;
   osc_cfg_pkg::clk_ctrl_s      next_ctrl;
   logic                        access;
   logic                        hit_cfg;
   logic                        hit_tune;
   logic                        hit_stat;

   function automatic logic [osc_cfg_pkg::ADDR_W-1:0] byte_addr(
      input logic [osc_cfg_pkg::ADDR_W-1:0] idx);
      byte_addr = {idx[osc_cfg_pkg::ADDR_W-3:0], 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Capture of the configuration byte

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state           <= osc_cfg_pkg::capture_wait;
         osc_config_high <= osc_cfg_pkg::CFG_RESET;
      end else if (ce) begin
         case (state)
            osc_cfg_pkg::capture_wait: begin
               osc_config_high <= config_byte_in;
               state           <= osc_cfg_pkg::running;
            end
            osc_cfg_pkg::running: begin
               state <= osc_cfg_pkg::running;
            end
            default: begin
               state <= osc_cfg_pkg::capture_wait;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decode

   always_comb begin
      logic [3:0] sel;
      logic       run_pll;
      sel     = osc_config_high[osc_cfg_pkg::SEL_LSB +: osc_cfg_pkg::SEL_W];
      run_pll = osc_tune_reg[osc_cfg_pkg::PLL_RUN_BIT];
      next_ctrl = '0;
      next_ctrl.osc_select = osc_cfg_pkg::osc_select_e'(sel);
      next_ctrl.two_speed_startup_en =
         osc_config_high[osc_cfg_pkg::TWO_SPEED_BIT];
      next_ctrl.failsafe_monitor_en =
         osc_config_high[osc_cfg_pkg::FAILSAFE_BIT];
      case (osc_cfg_pkg::osc_select_e'(sel))
         osc_cfg_pkg::ext_clock_low:
            next_ctrl.ext_clock_sel = 1'b1;
         osc_cfg_pkg::ext_clock_low_with_out: begin
            next_ctrl.ext_clock_sel = 1'b1;
            next_ctrl.clock_out_fn  = 1'b1;
         end
         osc_cfg_pkg::ext_clock_med:
            next_ctrl.ext_clock_sel = 1'b1;
         osc_cfg_pkg::ext_clock_med_with_out: begin
            next_ctrl.ext_clock_sel = 1'b1;
            next_ctrl.clock_out_fn  = 1'b1;
         end
         osc_cfg_pkg::ext_clock_high:
            next_ctrl.ext_clock_sel = 1'b1;
         osc_cfg_pkg::ext_clock_high_with_out: begin
            next_ctrl.ext_clock_sel = 1'b1;
            next_ctrl.clock_out_fn  = 1'b1;
         end
         osc_cfg_pkg::crystal_fast_med,
         osc_cfg_pkg::crystal_fast_high:
            next_ctrl.crystal_sel = 1'b1;
         osc_cfg_pkg::crystal_std_mode,
         osc_cfg_pkg::crystal_low_freq_mode:
            next_ctrl.crystal_sel = 1'b1;
         osc_cfg_pkg::ext_resistor_cap_osc:
            next_ctrl.rc_sel = 1'b1;
         osc_cfg_pkg::ext_resistor_cap_osc_out: begin
            next_ctrl.rc_sel       = 1'b1;
            next_ctrl.clock_out_fn = 1'b1;
         end
         osc_cfg_pkg::internal_osc_clock_out: begin
            next_ctrl.internal_sel = 1'b1;
            next_ctrl.clock_out_fn = 1'b1;
         end
         osc_cfg_pkg::internal_osc:
            next_ctrl.internal_sel = 1'b1;
         default:
            next_ctrl.mode_reserved = 1'b1;
      endcase
      if (next_ctrl.mode_reserved)
         next_ctrl.pll_enable = 1'b0;
      else if (next_ctrl.internal_sel)
         next_ctrl.pll_enable = run_pll;
      else
         next_ctrl.pll_enable = run_pll |
            osc_config_high[osc_cfg_pkg::PLL_FUSE_BIT];
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         clk_ctrl <= '0;
      else if (ce)
         clk_ctrl <= next_ctrl;
   end

   ////////////////////////////////////////////////////////////////////
   // APB slave

   assign pready   = ce;
   assign access   = psel & penable & ce;
   assign hit_cfg  = paddr == byte_addr(osc_cfg_pkg::CFG_IDX);
   assign hit_tune = paddr == byte_addr(osc_cfg_pkg::TUNE_IDX);
   assign hit_stat = paddr == byte_addr(osc_cfg_pkg::STAT_IDX);
   assign pslverr  = psel & penable & ~(hit_cfg | hit_tune | hit_stat);

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         osc_tune_reg <= osc_cfg_pkg::TUNE_RESET;
      else if (access && pwrite && hit_tune)
         osc_tune_reg <= pwdata[7:0];
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite && ce) begin
         prdata <= '0;
         if (hit_cfg) begin
            prdata[7:0] <= osc_config_high;
            prdata[osc_cfg_pkg::UNUSED_BIT] <= 1'b0;
         end else if (hit_tune) begin
            prdata[7:0] <= osc_tune_reg;
         end else if (hit_stat) begin
            prdata[$bits(osc_cfg_pkg::clk_ctrl_s)-1:0] <= clk_ctrl;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   two_speed_a: assert property (ce |=> clk_ctrl.two_speed_startup_en ==
      $past(osc_config_high[7])) else $error("two-speed mismatch");
   failsafe_a: assert property (ce |=> clk_ctrl.failsafe_monitor_en ==
      $past(osc_config_high[6])) else $error("monitor mismatch");
   unused_bit_a: assert property (psel && !penable && !pwrite && ce
      && hit_cfg |=> prdata[5] == 1'b0)
      else $error("unused bit read as one");
   pll_fuse_a: assert property (ce && osc_config_high[4] &&
      osc_config_high[3:0] inside {4'h0, 4'h5, 4'hD} |=> clk_ctrl.pll_enable)
      else $error("fuse did not enable pll");
   ext_low_a: assert property (ce && osc_config_high[3:0] == 4'hC |=>
      clk_ctrl.ext_clock_sel && clk_ctrl.clock_out_fn)
      else $error("low external clock out wrong");
   ext_med_a: assert property (ce && osc_config_high[3:0] == 4'hB |=>
      clk_ctrl.ext_clock_sel && !clk_ctrl.clock_out_fn)
      else $error("medium external clock wrong");
   ext_high_a: assert property (ce && osc_config_high[3:0] == 4'h4 |=>
      clk_ctrl.ext_clock_sel && clk_ctrl.clock_out_fn)
      else $error("high external clock wrong");
   crystal_a: assert property (ce && osc_config_high[3:0] <= 4'h3 |=>
      clk_ctrl.crystal_sel && !clk_ctrl.clock_out_fn)
      else $error("crystal decode wrong");
   rc_out_a: assert property (ce && osc_config_high[3:0] == 4'h6 |=>
      clk_ctrl.rc_sel && clk_ctrl.clock_out_fn)
      else $error("rc output decode wrong");
   internal_out_a: assert property (ce && osc_config_high[3:0] == 4'h9 |=>
      clk_ctrl.internal_sel && clk_ctrl.clock_out_fn)
      else $error("internal output decode wrong");
   internal_pll_a: assert property (ce && osc_config_high[3:0] == 4'h9 |=>
      clk_ctrl.pll_enable == $past(osc_tune_reg[6]))
      else $error("internal pll not from runtime bit");
   other_pll_a: assert property (ce && osc_config_high[3:0] == 4'h2 |=>
      clk_ctrl.pll_enable == $past(osc_tune_reg[6] | osc_config_high[4]))
      else $error("pll enable not or of sources");
   held_cfg_a: assert property (state == osc_cfg_pkg::running |=>
      $stable(osc_config_high)) else $error("config byte changed");
   reserved_a: assert property (ce && osc_config_high[3:0] == 4'hE |=>
      clk_ctrl.mode_reserved && !clk_ctrl.pll_enable)
      else $error("reserved code not flagged");
   crystal_std_a: assert property (ce && osc_config_high[3:1] == 3'b000
      |=> clk_ctrl.crystal_sel && !clk_ctrl.ext_clock_sel)
      else $error("standard crystal decode wrong");
   ext_low_in_a: assert property (ce && osc_config_high[3:0] == 4'hD |=>
      clk_ctrl.ext_clock_sel && !clk_ctrl.clock_out_fn)
      else $error("low external clock wrong");
   ce_freeze_a: assert property (!ce |=> $stable(clk_ctrl))
      else $error("controls moved with ce low");

   pll_on_c: cover property (clk_ctrl.pll_enable && clk_ctrl.internal_sel);
   tune_wr_c: cover property (access && pwrite && hit_tune);
   bad_addr_c: cover property (pslverr);
   clk_out_c: cover property (clk_ctrl.clock_out_fn && clk_ctrl.rc_sel);

endmodule // oscillator_config_decode

// *** bench/oscillator_config_decode_test.sv ***
/*
 Self-checking bench of the oscillator configuration decoder.
 Assumes the design package and a zero-wait APB slave with ce held high.
*/
`timescale 1ns/100ps
module oscillator_config_decode_test;
   logic                                clk;
   logic                                reset;
   logic                                ce;
   logic [7:0]                          config_byte_in;
   logic                                psel;
   logic                                penable;
   logic                                pwrite;
   logic [osc_cfg_pkg::ADDR_W-1:0]      paddr;
   logic [osc_cfg_pkg::DATA_W-1:0]      pwdata;
   logic                                pready;
   logic                                pslverr;
   logic [osc_cfg_pkg::DATA_W-1:0]      prdata;
   osc_cfg_pkg::clk_ctrl_s              clk_ctrl;
   int                                  err_total;
   int                                  comparisons;
   localparam logic [23:0] CFG_ADDR  = 24'hC00004;
   localparam logic [23:0] TUNE_ADDR = 24'hC00040;
   localparam logic [23:0] BAD_ADDR  = 24'hC00080;

   oscillator_config_decode uut (.clk(clk), .reset(reset), .ce(ce),
      .config_byte_in(config_byte_in), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .clk_ctrl(clk_ctrl));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Reference decode of the byte and the runtime enable
   function automatic logic [12:0] expect_ctrl(logic [7:0] b, logic run);
      logic [3:0] c;
      logic       in_o, rsv, cry, rc, co, pll;
      c    = b[3:0];
      in_o = (c[3:1] == 3'b100);
      rsv  = (c[3:1] == 3'b111);
      cry  = (c[3:2] == 2'b00);
      rc   = (c[3:1] == 3'b011);
      co   = (c inside {4'hC, 4'hA, 4'h4, 4'h6, 4'h9});
      pll  = rsv ? 1'b0 : (in_o ? run : (b[4] | run));
      return {b[7], b[6], pll, co, in_o, cry, !(in_o | rsv | cry | rc),
              rc, rsv, c};
   endfunction

   task automatic apb(logic wr, logic [23:0] a, logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check("pready", {31'b0, pready}, 32'h00000001);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic restart(logic [7:0] b);
      config_byte_in <= b;
      reset          <= 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic scan_codes();
      logic [7:0]  b;
      logic [31:0] rd;
      logic        er;
      for (int i = 0; i < 16; i++) begin
         b = {i[0], i[1], 1'b1, i[2] ^ i[0], 4'(i)};
         restart(b);
         check("ctrl", 32'(clk_ctrl), 32'(expect_ctrl(b, 1'b0)));
         apb(1'b0, CFG_ADDR, 32'h0, rd, er);
         check("cfg read", rd, {24'h0, b & 8'hDF});
         check("cfg err", {31'b0, er}, 32'h0);
      end
   endtask

   task automatic runtime_pll(logic [7:0] b);
      logic [31:0] rd;
      logic        er;
      restart(b);
      check("pll idle", 32'(clk_ctrl), 32'(expect_ctrl(b, 1'b0)));
      apb(1'b1, TUNE_ADDR, 32'h00000040, rd, er);
      repeat (2) @(posedge clk);
      #1;
      check("pll run", 32'(clk_ctrl), 32'(expect_ctrl(b, 1'b1)));
      apb(1'b0, TUNE_ADDR, 32'h0, rd, er);
      check("tune read", rd, 32'h00000040);
      apb(1'b1, TUNE_ADDR, 32'h0, rd, er);
      repeat (2) @(posedge clk);
      #1;
      check("pll off", 32'(clk_ctrl), 32'(expect_ctrl(b, 1'b0)));
   endtask

   task automatic refusals();
      logic [31:0] rd;
      logic        er;
      restart(8'h93);
      apb(1'b1, CFG_ADDR, 32'h000000FF, rd, er);
      repeat (2) @(posedge clk);
      #1;
      check("cfg held", 32'(clk_ctrl), 32'(expect_ctrl(8'h93, 1'b0)));
      apb(1'b0, CFG_ADDR, 32'h0, rd, er);
      check("cfg kept", rd, 32'h00000093);
      apb(1'b0, BAD_ADDR, 32'h0, rd, er);
      check("bad err", {31'b0, er}, 32'h00000001);
      check("bad data", rd, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0;
      comparisons = 0;
      reset = 1'b1;
      ce = 1'b1;
      config_byte_in = 8'h08;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      scan_codes();
      runtime_pll(8'h19);
      runtime_pll(8'h08);
      runtime_pll(8'h01);
      refusals();
      conclude();
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      conclude();
   end
endmodule // oscillator_config_decode_test
